// File: dv/dscw_checker_assertions.sv
`default_nettype none
module dscw_checker
   import dscw_pkg::*;
(
   input wire logic        CLK_SYS_I,
   input wire logic        RST_N_I,
   input wire logic        PAR_WR_I,
   input wire logic        PAR_RD_I,
   input wire logic [15:0] PAR_ADDR_I,
   input wire logic [15:0] PAR_WDATA_I,
   input wire logic [15:0] PAR_RDATA_O,
   input wire logic        FAULT_I,
   input wire logic        VOLTAGE_OK_I,
   input wire logic [2:0]  DRIVE_STATE_O,
   input wire logic        HALT_O,
   input wire logic [2:0]  MODE_BITS_O,
   input wire logic [15:0] MODE_ACTIVE_O,
   input wire logic        MODE_BUSY_O,
   input wire logic        MODE_GO_O,
   input wire logic [2:0]  JOG_O
);
   timeunit 1ns;
   timeprecision 1ns;
   import dscw_pkg::*;
   // Report pattern per state, X bits read as zero, voltage bit masked
   localparam logic [6:0] ENC [8] = '{7'h00, 7'h40, 7'h21, 7'h23,
                                      7'h27, 7'h07, 7'h0F, 7'h0F};
   logic [15:0] cmd_sh;
   logic [2:0]  jog_sh;
   logic [1:0]  age;

   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RST_N_I);

   ////////////////////////////////////////////////////////////////////////
   // Shadow of the last written words; age lets the pipeline settle first
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cmd_sh <= 16'h0000;
         jog_sh <= 3'h0;
         age    <= 2'h0;
      end
      else if (PAR_WR_I) begin
         age <= 2'h0;
         if (PAR_ADDR_I == ADDR_COMMAND_WORD) begin
            cmd_sh <= PAR_WDATA_I;
         end
         if (PAR_ADDR_I == ADDR_JOG_REQUEST) begin
            jog_sh <= PAR_WDATA_I[2:0];
         end
      end
      else if (age != 2'h3) begin
         age <= age + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   cmd_echo_a: assert property (age == 2'h3 |-> HALT_O == cmd_sh[8]
      && MODE_BITS_O == cmd_sh[6:4]) else $error("halt or mode bits stale");
   jog_echo_a: assert property (age == 2'h3 |-> JOG_O == jog_sh)
      else $error("jog bits stale");
   go_pulse_a: assert property (MODE_GO_O |=> !MODE_GO_O)
      else $error("start strobe longer than one cycle");
   go_busy_a: assert property (MODE_GO_O |-> MODE_BUSY_O)
      else $error("start strobe without running mode");
   // Voltage pin reaches the gate through two flops, hence depth three
   mode_gate_a: assert property ($rose(MODE_BUSY_O) |->
      $past(DRIVE_STATE_O) == ST_OPER_EN && $past(VOLTAGE_OK_I, 3))
      else $error("mode started outside operation enabled");
   mode_range_a: assert property (MODE_BUSY_O |->
      $signed(MODE_ACTIVE_O) >= MODE_MIN && $signed(MODE_ACTIVE_O) <= MODE_MAX)
      else $error("active mode out of range");
   mode_hold_a: assert property (MODE_BUSY_O && $past(MODE_BUSY_O) |->
      $stable(MODE_ACTIVE_O)) else $error("mode changed while running");
   busy_drop_a: assert property (MODE_BUSY_O &&
      DRIVE_STATE_O != ST_OPER_EN |-> ##[0:2] !MODE_BUSY_O)
      else $error("mode kept running outside operation enabled");
   fault_entry_a: assert property ($rose(FAULT_I) |->
      ##[2:6] DRIVE_STATE_O == ST_FAULT) else $error("fault not entered");
   state_report_a: assert property ($past(PAR_RD_I) &&
      $past(PAR_ADDR_I) == ADDR_STATE_REPORT |->
      (PAR_RDATA_O[6:0] & 7'h6F) == ENC[$past(DRIVE_STATE_O)])
      else $error("state report pattern wrong");
endmodule : dscw_checker
`default_nettype wire

// File: dv/dscw_master.sv
`default_nettype none
module dscw_master
(
   input  wire logic        clk_i,
   input  wire logic [15:0] rdata_i,
   output logic             wr_o,
   output logic             rd_o,
   output logic      [15:0] addr_o,
   output logic      [15:0] wdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import dscw_pkg::*;
   // Idle bus at time zero
   initial begin
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      addr_o  = 16'h0000;
      wdata_o = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // One write, strobe held for one taking edge; idle lines show no stale
   // value so a design sampling them late is caught
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_i);
      wr_o    <= 1'b1;
      addr_o  <= a;
      wdata_o <= (a == ADDR_COMMAND_WORD) ? (d & 16'h01FF) : d;
      @(posedge clk_i);
      wr_o    <= 1'b0;
      addr_o  <= ~a;
      wdata_o <= ~d;
   endtask : wr

   // One read; data is taken one cycle after the taking edge
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge clk_i);
      rd_o   <= 1'b1;
      addr_o <= a;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      addr_o <= ~a;
      @(posedge clk_i);
      #1;
      d = rdata_i;
   endtask : rd
endmodule : dscw_master
`default_nettype wire

// File: dv/test_drive_state_control_word.sv
`default_nettype none
module test_drive_state_control_word;
   timeunit 1ns;
   timeprecision 1ns;
   import dscw_pkg::*;
   logic        clk, rst_n, en, fclr, flt, vok, still;
   logic        wr, rd, halt, busy, go;
   logic [15:0] addr, wdata, rdata, mact, d;
   logic [2:0]  st, mbits, jog;
   int          n_errors = 0;
   int          n_checks = 0;

   dscw_master m (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
      .addr_o(addr), .wdata_o(wdata));
   dscw_top dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PAR_WR_I(wr),
      .PAR_RD_I(rd), .PAR_ADDR_I(addr), .PAR_WDATA_I(wdata),
      .PAR_RDATA_O(rdata), .ENABLE_I(en), .FAULT_CLEAR_I(fclr),
      .FAULT_I(flt), .VOLTAGE_OK_I(vok), .STANDSTILL_I(still),
      .DRIVE_STATE_O(st), .HALT_O(halt), .MODE_BITS_O(mbits),
      .MODE_ACTIVE_O(mact), .MODE_BUSY_O(busy), .MODE_GO_O(go),
      .JOG_O(jog));

   // System clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end
      else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Bounded wait for a state; running out ends the run
   // First look is off the edge, so a value launched there has settled
   task automatic wst(input logic [2:0] e);
      int i;
      #1;
      for (i = 0; i < 20 && st !== e; i++) begin
         @(posedge clk);
         #1;
      end
      chk({13'h0, st}, {13'h0, e});
      if (st !== e) conclude();
   endtask : wst

   // Count start strobes over a short window; the first sample falls in
   // the cycle right after the taking edge, where an accept strobe stands
   task automatic ngo(input logic [15:0] e);
      int n = 0;
      repeat (6) begin
         #1;
         n += (go === 1'b1);
         @(posedge clk);
      end
      chk(16'(n), e);
   endtask : ngo

   task automatic cw(input logic [15:0] v);
      m.wr(ADDR_COMMAND_WORD, v);
   endtask : cw

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      m.rd(ADDR_COMMAND_WORD, d);
      chk(d, COMMAND_WORD_RST);
      m.rd(ADDR_JOG_REQUEST, d);
      chk(d, 16'h0000);
      m.rd(16'h1B00, d);
      chk(d, 16'h0000);
      wst(ST_SW_ON_DIS);
   endtask : t_reset

   task automatic t_bus;
      cw(16'h008E);
      wst(ST_READY);
      m.rd(ADDR_STATE_REPORT, d);
      chk(d & 16'h006F, 16'h0021);
      cw(16'h000F);
      wst(ST_OPER_EN);
      cw(16'h0007);
      wst(ST_SWITCHED_ON);
      cw(16'h0001);
      wst(ST_SW_ON_DIS);
      cw(16'h000F);
      repeat (4) @(posedge clk);
      wst(ST_SW_ON_DIS);
   endtask : t_bus

   task automatic t_mode;
      cw(16'h0006);
      cw(16'h015F);
      wst(ST_OPER_EN);
      chk({15'h0, halt}, 16'h0001);
      chk({13'h0, mbits}, 16'h0005);
      m.wr(ADDR_JOG_REQUEST, 16'hFFF5);
      m.rd(ADDR_JOG_REQUEST, d);
      chk(d, 16'h0005);
      chk({13'h0, jog}, 16'h0005);
      m.wr(ADDR_MODE_SELECT, 16'h0007);
      ngo(16'h0000);
      m.wr(ADDR_MODE_SELECT, 16'hFFFF);
      ngo(16'h0001);
      chk(mact, 16'hFFFF);
      m.wr(ADDR_MODE_SELECT, 16'h0003);
      ngo(16'h0000);
      chk(mact, 16'hFFFF);
      @(posedge clk);
      still <= 1'b1;
      repeat (6) @(posedge clk);
      chk({15'h0, busy}, 16'h0000);
      still <= 1'b0;
      cw(16'h000F);
      m.wr(ADDR_MODE_SELECT, 16'h0001);
      ngo(16'h0000);
      cw(16'h001F);
      ngo(16'h0001);
   endtask : t_mode

   task automatic t_quick;
      cw(16'h000B);
      wst(ST_QUICK_STOP);
      @(posedge clk);
      still <= 1'b1;
      wst(ST_SW_ON_DIS);
      @(posedge clk);
      still <= 1'b0;
   endtask : t_quick

   task automatic t_local;
      cw(16'h0006);
      wst(ST_READY);
      @(posedge clk);
      en <= 1'b1;
      wst(ST_OPER_EN);
      @(posedge clk);
      en <= 1'b0;
      wst(ST_READY);
   endtask : t_local

   task automatic t_fault;
      cw(16'h000F);
      wst(ST_OPER_EN);
      m.wr(ADDR_MODE_SELECT, 16'h0003);
      ngo(16'h0001);
      @(posedge clk);
      flt <= 1'b1;
      wst(ST_FAULT);
      chk({15'h0, busy}, 16'h0000);
      @(posedge clk);
      flt <= 1'b0;
      cw(16'h0000);
      cw(16'h0080);
      wst(ST_SW_ON_DIS);
      cw(16'h0006);
      cw(16'h000F);
      wst(ST_OPER_EN);
      @(posedge clk);
      flt <= 1'b1;
      wst(ST_FAULT);
      @(posedge clk);
      flt <= 1'b0;
      en  <= 1'b1;
      @(posedge clk);
      fclr <= 1'b1;
      wst(ST_OPER_EN);
   endtask : t_fault

   ////////////////////////////////////////////////////////////////////////
   // Reset for ten cycles, then run every scenario in turn
   initial begin
      rst_n = 1'b0;
      en    = 1'b0;
      fclr  = 1'b0;
      flt   = 1'b0;
      vok   = 1'b1;
      still = 1'b0;
      repeat (10) @(posedge clk);
      chk({13'h0, st}, {13'h0, ST_NOT_READY});
      rst_n <= 1'b1;
      t_reset();
      t_bus();
      t_mode();
      t_quick();
      t_local();
      t_fault();
      conclude();
   end
endmodule : test_drive_state_control_word

bind dscw_top dscw_checker chk_i (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
   .PAR_WR_I(PAR_WR_I), .PAR_RD_I(PAR_RD_I), .PAR_ADDR_I(PAR_ADDR_I),
   .PAR_WDATA_I(PAR_WDATA_I), .PAR_RDATA_O(PAR_RDATA_O), .FAULT_I(FAULT_I),
   .VOLTAGE_OK_I(VOLTAGE_OK_I), .DRIVE_STATE_O(DRIVE_STATE_O),
   .HALT_O(HALT_O), .MODE_BITS_O(MODE_BITS_O), .MODE_GO_O(MODE_GO_O),
   .MODE_ACTIVE_O(MODE_ACTIVE_O), .MODE_BUSY_O(MODE_BUSY_O), .JOG_O(JOG_O));
`default_nettype wire

// File: rtl/dscw_pkg.sv
`default_nettype none
package dscw_pkg;

   // Parameter addresses on the fieldbus parameter port
   localparam logic [15:0] ADDR_COMMAND_WORD = 16'h1B02;
   localparam logic [15:0] ADDR_STATE_REPORT = 16'h1B04;
   localparam logic [15:0] ADDR_MODE_SELECT  = 16'h1B06;
   localparam logic [15:0] ADDR_MODE_ACTIVE  = 16'h1B08;
   localparam logic [15:0] ADDR_JOG_REQUEST  = 16'h1B12;

   // Reset values
   localparam logic [15:0] COMMAND_WORD_RST  = 16'h0000;
   localparam logic [2:0]  JOG_REQUEST_RST   = 3'h0;
   localparam logic [15:0] MODE_SELECT_RST   = 16'h0000;

   // Command word fields
   localparam int CW_SWITCH_ON   = 0;
   localparam int CW_EN_VOLTAGE  = 1;
   localparam int CW_QUICK_STOP  = 2;
   localparam int CW_EN_OPER     = 3;
   localparam int CW_MODE_LSB    = 4;
   localparam int CW_MODE_MSB    = 6;
   localparam int CW_FAULT_RESET = 7;
   localparam int CW_HALT        = 8;

   // State report fields
   localparam int SR_READY       = 0;
   localparam int SR_SWITCHED_ON = 1;
   localparam int SR_OPER_EN     = 2;
   localparam int SR_FAULT       = 3;
   localparam int SR_VOLTAGE     = 4;
   localparam int SR_QUICK_STOP  = 5;
   localparam int SR_SW_ON_DIS   = 6;
   localparam int SR_HALT        = 8;

   // Operating mode codes
   localparam logic signed [15:0] MODE_MIN      = -16'sd6;
   localparam logic signed [15:0] MODE_MAX      = 16'sd6;
   localparam logic signed [15:0] MODE_PROF_POS = 16'sd1;
   localparam logic signed [15:0] MODE_PROF_VEL = 16'sd3;
   localparam logic signed [15:0] MODE_HOMING   = 16'sd6;
   localparam logic signed [15:0] MODE_JOG      = -16'sd1;

   // Operating states, numbered 2 to 9 in the state report
   typedef enum logic [2:0] {
      ST_NOT_READY,
      ST_SW_ON_DIS,
      ST_READY,
      ST_SWITCHED_ON,
      ST_OPER_EN,
      ST_QUICK_STOP,
      ST_FAULT_REACT,
      ST_FAULT
   } dscw_state_t;

   // Local enable stepping goal
   typedef enum logic [1:0] {
      GOAL_NONE,
      GOAL_UP,
      GOAL_DOWN
   } dscw_goal_t;

endpackage : dscw_pkg
`default_nettype wire

// File: rtl/dscw_top.sv
// How it works
// - State changes come from fieldbus writes, local inputs, or automatic events.
// - Only command bits 0-3 and 7 decode; bit 7 rising clears fault to 3.
// - Pattern x110 is shutdown: states 3, 5, 6 go to state 4.
// - Pattern 111 switches on; bit 3 then selects state 5 or state 6.
// - Bit 1 clear disables voltage: states 4 to 7 go to state 3.
// - Bit 2 clear with bit 1 set is quick stop: to 3 or to 7.
// - Don't-care bits never affect whether a transition is taken.
// - Bits 4-6 are mode settings and never steer the state machine.
// - Command bit 8 set holds a halt request on the motion.
// - One mode at a time; a new mode only after the old one ended.
// - Mode ends at standstill; a fault cancels it and allows a new start.
// - Mode selection is accepted only in state 6 with the voltage OK pin high.
// - Jog request is written first; the mode-select write starts the mode.
// - Mode select accepts -6 to 6; 1, 3, 6 and -1 are named modes.
// - Jog bits: 0 positive, 1 negative, 2 fast; value range 0 to 7.
// - Position and homing modes start on a rising command bit 4.
// - Other modes see bits 4-6 as mode-specific settings.
// - State report bits 0-3, 5, 6 encode states 2 to 9.
`default_nettype none
module dscw_top
   import dscw_pkg::*;
(
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_N_I,
   input  wire logic        PAR_WR_I,
   input  wire logic        PAR_RD_I,
   input  wire logic [15:0] PAR_ADDR_I,
   input  wire logic [15:0] PAR_WDATA_I,
   output logic      [15:0] PAR_RDATA_O,
   input  wire logic        ENABLE_I,
   input  wire logic        FAULT_CLEAR_I,
   input  wire logic        FAULT_I,
   input  wire logic        VOLTAGE_OK_I,
   input  wire logic        STANDSTILL_I,
   output logic      [2:0]  DRIVE_STATE_O,
   output logic             HALT_O,
   output logic      [2:0]  MODE_BITS_O,
   output logic      [15:0] MODE_ACTIVE_O,
   output logic             MODE_BUSY_O,
   output logic             MODE_GO_O,
   output logic      [2:0]  JOG_O
);
   import dscw_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [4:0] pin_meta;
   logic [4:0] pin_sync;
   logic [1:0] edge_prev;

   // Every pin passes two flops before anything looks at it
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pin_meta <= 5'h00;
         pin_sync <= 5'h00;
      end else begin
         pin_meta <= {STANDSTILL_I, VOLTAGE_OK_I, FAULT_I,
                      FAULT_CLEAR_I, ENABLE_I};
         pin_sync <= pin_meta;
      end
   end

   logic en_lvl;
   logic clr_lvl;
   logic fault_lvl;
   logic volt_ok;
   logic standstill;
   assign en_lvl     = pin_sync[0];
   assign clr_lvl    = pin_sync[1];
   assign fault_lvl  = pin_sync[2];
   assign volt_ok    = pin_sync[3];
   assign standstill = pin_sync[4];

   // Edge memory for enable and fault-clear
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         edge_prev <= 2'h0;
      end else begin
         edge_prev <= {clr_lvl, en_lvl};
      end
   end

   logic en_rise;
   logic en_fall;
   logic clr_rise;
   assign en_rise  = en_lvl & ~edge_prev[0];
   assign en_fall  = ~en_lvl & edge_prev[0];
   assign clr_rise = clr_lvl & ~edge_prev[1];

   ////////////////////////////////////////////////////////////////////////
   // Parameter registers

   logic [15:0]        cmd_word;
   logic [2:0]         jog_req;
   logic signed [15:0] mode_sel;
   logic signed [15:0] mode_act;
   logic               mode_busy;
   logic               cmd_pending;
   logic               wr_cmd;
   logic               wr_mode;
   logic               wr_jog;
   logic               fault_edge;
   logic               mode_ok;
   logic               mode_accept;
   dscw_state_t        state;

   assign wr_cmd  = PAR_WR_I && (PAR_ADDR_I == ADDR_COMMAND_WORD);
   assign wr_mode = PAR_WR_I && (PAR_ADDR_I == ADDR_MODE_SELECT);
   assign wr_jog  = PAR_WR_I && (PAR_ADDR_I == ADDR_JOG_REQUEST);

   // Fault reset is an edge of bit 7 between old and new word
   assign fault_edge = wr_cmd && PAR_WDATA_I[CW_FAULT_RESET]
                       && !cmd_word[CW_FAULT_RESET];

   // Mode code must be in range, drive enabled and previous mode ended
   assign mode_ok = ($signed(PAR_WDATA_I) >= MODE_MIN)
                    && ($signed(PAR_WDATA_I) <= MODE_MAX);
   assign mode_accept = wr_mode && mode_ok
                        && (state == ST_OPER_EN) && volt_ok
                        && !mode_busy;

   // Command word stored whole; reserved bits are the master's duty
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cmd_word <= COMMAND_WORD_RST;
      end else if (wr_cmd) begin
         cmd_word <= PAR_WDATA_I;
      end
   end

   // Jog request keeps only its three defined bits
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         jog_req <= JOG_REQUEST_RST;
      end else if (wr_jog) begin
         jog_req <= PAR_WDATA_I[2:0];
      end
   end

   // Selected mode reads back what was last accepted
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mode_sel <= MODE_SELECT_RST;
      end else if (mode_accept) begin
         mode_sel <= $signed(PAR_WDATA_I);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operating state machine

   dscw_state_t next_state;
   dscw_goal_t  goal;
   dscw_goal_t  next_goal;
   logic [3:0]  cmd_bits;
   logic        cmd_step;

   // Bus commands are re-evaluated after a write until nothing moves,
   // so 1111 from state 4 walks through 5 into 6
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cmd_pending <= 1'b0;
      end else if (wr_cmd) begin
         cmd_pending <= 1'b1;
      end else if (!cmd_step) begin
         cmd_pending <= 1'b0;
      end
   end

   // Only bits 0 to 3 take part; 4 to 6 and 8 never steer a state
   assign cmd_bits = cmd_word[3:0];

   always_comb begin
      next_state = state;
      next_goal  = goal;
      cmd_step   = 1'b0;
      if (en_rise) begin
         next_goal = GOAL_UP;
      end else if (en_fall) begin
         next_goal = GOAL_DOWN;
      end
      unique case (state)
         ST_NOT_READY: begin
            if (volt_ok) begin
               next_state = ST_SW_ON_DIS;
            end
         end
         ST_FAULT_REACT: begin
            next_state = ST_FAULT;
         end
         ST_FAULT: begin
            if (fault_edge && !fault_lvl) begin
               next_state = ST_SW_ON_DIS;
            end else if (clr_rise && !fault_lvl) begin
               next_state = ST_READY;
               next_goal  = en_lvl ? GOAL_UP : GOAL_NONE;
            end
         end
         default: begin
            if (fault_lvl) begin
               next_state = ST_FAULT_REACT;
               next_goal  = GOAL_NONE;
            end else if (cmd_pending) begin
               cmd_step = 1'b1;
               // Checks run in order so masked bits cannot matter
               if (!cmd_bits[CW_EN_VOLTAGE]) begin
                  if (state != ST_SW_ON_DIS) begin
                     next_state = ST_SW_ON_DIS;
                  end else begin
                     cmd_step = 1'b0;
                  end
               end else if (!cmd_bits[CW_QUICK_STOP]) begin
                  if (state == ST_OPER_EN) begin
                     next_state = ST_QUICK_STOP;
                  end else if (state == ST_READY
                               || state == ST_SWITCHED_ON) begin
                     next_state = ST_SW_ON_DIS;
                  end else begin
                     cmd_step = 1'b0;
                  end
               end else if (!cmd_bits[CW_SWITCH_ON]) begin
                  if (state == ST_SW_ON_DIS || state == ST_SWITCHED_ON
                      || state == ST_OPER_EN) begin
                     next_state = ST_READY;
                  end else begin
                     cmd_step = 1'b0;
                  end
               end else if (state == ST_READY) begin
                  next_state = ST_SWITCHED_ON;
               end else if (state == ST_SWITCHED_ON
                            && cmd_bits[CW_EN_OPER]) begin
                  next_state = ST_OPER_EN;
               end else if ((state == ST_OPER_EN
                             || state == ST_QUICK_STOP)
                            && !cmd_bits[CW_EN_OPER]) begin
                  next_state = ST_SWITCHED_ON;
               end else if (state == ST_QUICK_STOP) begin
                  next_state = ST_OPER_EN;
               end else begin
                  cmd_step = 1'b0;
               end
            end else if (state == ST_QUICK_STOP && standstill) begin
               next_state = ST_SW_ON_DIS;
            end else if (goal == GOAL_UP) begin
               if (state == ST_READY) begin
                  next_state = ST_SWITCHED_ON;
               end else if (state == ST_SWITCHED_ON) begin
                  next_state = ST_OPER_EN;
                  next_goal  = GOAL_NONE;
               end else begin
                  next_goal = GOAL_NONE;
               end
            end else if (goal == GOAL_DOWN) begin
               if (state == ST_OPER_EN) begin
                  next_state = ST_SWITCHED_ON;
               end else if (state == ST_SWITCHED_ON) begin
                  next_state = ST_READY;
                  next_goal  = GOAL_NONE;
               end else begin
                  next_goal = GOAL_NONE;
               end
            end
         end
      endcase
   end

   // State and local goal registers
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state <= ST_NOT_READY;
         goal  <= GOAL_NONE;
      end else begin
         state <= next_state;
         goal  <= next_goal;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operating modes

   logic go_bit_prev;

   // A mode runs until standstill; a fault cancels it outright
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mode_busy <= 1'b0;
         mode_act  <= MODE_SELECT_RST;
      end else if (mode_accept) begin
         mode_busy <= 1'b1;
         mode_act  <= $signed(PAR_WDATA_I);
      end else if (standstill || state != ST_OPER_EN) begin
         mode_busy <= 1'b0;
      end
   end

   // Position and homing wait for command bit 4 to start
   function automatic logic dscw_waits_bit4(input logic signed [15:0] m);
      return (m == MODE_PROF_POS) || (m == MODE_HOMING);
   endfunction : dscw_waits_bit4

   // Start strobe: judged on the code being accepted, since the active
   // mode still holds the old code in the accepting cycle
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         go_bit_prev <= 1'b0;
         MODE_GO_O   <= 1'b0;
      end else begin
         go_bit_prev <= cmd_word[CW_MODE_LSB];
         if (mode_accept) begin
            MODE_GO_O <= !dscw_waits_bit4($signed(PAR_WDATA_I));
         end else begin
            MODE_GO_O <= dscw_waits_bit4(mode_act) && mode_busy
                         && (state == ST_OPER_EN)
                         && cmd_word[CW_MODE_LSB] && !go_bit_prev;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State report and read port

   // Fixed patterns of flags bits 6,5,3,2,1,0 per state
   function automatic logic [15:0] dscw_report(input dscw_state_t st,
                                               input logic volt,
                                               input logic halt);
      logic [15:0] r;
      r = 16'h0000;
      unique case (st)
         ST_NOT_READY:   r = 16'h0000;
         ST_SW_ON_DIS:   r = 16'h0040;
         ST_READY:       r = 16'h0021;
         ST_SWITCHED_ON: r = 16'h0023;
         ST_OPER_EN:     r = 16'h0027;
         ST_QUICK_STOP:  r = 16'h0007;
         ST_FAULT_REACT: r = 16'h000F;
         ST_FAULT:       r = 16'h000F;
      endcase
      r[SR_VOLTAGE] = volt;
      r[SR_HALT]    = halt;
      return r;
   endfunction : dscw_report

   // Read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PAR_RDATA_O <= 16'h0000;
      end else if (PAR_RD_I) begin
         unique case (PAR_ADDR_I)
            ADDR_COMMAND_WORD: PAR_RDATA_O <= cmd_word;
            ADDR_STATE_REPORT: PAR_RDATA_O <= dscw_report(state, volt_ok,
                                   cmd_word[CW_HALT]);
            ADDR_MODE_SELECT:  PAR_RDATA_O <= mode_sel;
            ADDR_MODE_ACTIVE:  PAR_RDATA_O <= mode_act;
            ADDR_JOG_REQUEST:  PAR_RDATA_O <= {13'h0000, jog_req};
            default:           PAR_RDATA_O <= 16'h0000;
         endcase
      end
   end

   // Status outputs straight from flops
   assign DRIVE_STATE_O = state;
   assign HALT_O        = cmd_word[CW_HALT];
   assign MODE_BITS_O   = cmd_word[CW_MODE_MSB:CW_MODE_LSB];
   assign MODE_ACTIVE_O = mode_act;
   assign MODE_BUSY_O   = mode_busy;
   assign JOG_O         = jog_req;

endmodule : dscw_top
`default_nettype wire
